// >>> bench/exram_host_model.sv
// Behavioural host processor that runs byte cycles on the parallel bus of the port.
`default_nettype none
module exram_host_model (
   output logic ce_n, // Chip enable, active low.
   output logic oe_n, // Output enable, active low.
   output logic we_n, // Write enable, active low.
   output logic [4:0] addr, // Register address.
   output logic [7:0] data_in, // Level seen on the data pins.
   input wire logic clk, // System clock.
   input wire logic [7:0] data_out, // Byte driven by the device.
   input wire logic data_oe // High while the device drives the pins.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] host_bus;

   // The pins carry the device's byte while it drives, else the host's own level.
   assign data_in = data_oe ? data_out : host_bus;

   // Bus idle at time zero.
   initial begin
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      addr = 5'h00;
      host_bus = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One access; each strobe phase lasts five cycles because the pins pass a
   // two-flop synchroniser and a shorter phase could be missed altogether.
   task automatic bus_cycle(input logic [4:0] a, input logic wr, input logic [7:0] d,
                            output logic [7:0] q);
      @(posedge clk);
      #10;
      addr = a;
      if (wr) begin
         host_bus = d;
      end
      ce_n = 1'b0;
      oe_n = wr;
      we_n = !wr;
      repeat (5) @(posedge clk);
      q = data_in;
      #10;
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      host_bus = ~host_bus; // Released pins show the inverse, not a stale byte.
      repeat (5) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// >>> bench/tb_exram_port.sv
// Self-checking testbench of the extended RAM port with its battery flags.
`include "exram_defines.svh"
`default_nettype none
module tb_exram_port;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TIMEOUT_CYC = 6000;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic main_battery_below = 1'b0;
   logic aux_battery_below = 1'b0;
   logic ce_n, oe_n, we_n, data_oe;
   logic [4:0] addr;
   logic [7:0] data_in, data_out;
   int error_cnt = 0;
   int n_compared = 0;
   int cyc = 0;

   exram_port exram_port_i (.clk(clk), .arst_n(arst_n), .ce_n(ce_n), .oe_n(oe_n),
      .we_n(we_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .main_battery_below(main_battery_below), .aux_battery_below(aux_battery_below));
   exram_host_model exram_host_model_i (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
      .data_in(data_in), .clk(clk), .data_out(data_out), .data_oe(data_oe));

   // Free-running 10 MHz clock.
   always #50 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and the watchdog that cuts a hang short.
   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == TIMEOUT_CYC) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] dummy;
      exram_host_model_i.bus_cycle(a, 1'b1, d, dummy);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] got;
      exram_host_model_i.bus_cycle(a, 1'b0, 8'h00, got);
      check(got, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // All four comparator combinations reach the two status flags.
   task automatic flags_test();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         #10;
         main_battery_below = i[1];
         aux_battery_below = i[0];
         repeat (4) @(posedge clk);
         rd(`EXRAM_OFS_STATUS, {i[1], i[0], 6'h00});
      end
   endtask

   // Both ends of the span hold their own byte; burst off leaves the pointer alone.
   task automatic single_test();
      wr(`EXRAM_OFS_POINTER, 8'h00);
      wr(`EXRAM_OFS_DATA, 8'ha5);
      wr(`EXRAM_OFS_POINTER, 8'hff);
      wr(`EXRAM_OFS_DATA, 8'h5a);
      wr(`EXRAM_OFS_DATA, 8'h3c);
      rd(`EXRAM_OFS_POINTER, 8'hff);
      rd(`EXRAM_OFS_DATA, 8'h3c);
      rd(`EXRAM_OFS_DATA, 8'h3c);
      wr(`EXRAM_OFS_POINTER, 8'h00);
      rd(`EXRAM_OFS_DATA, 8'ha5);
      rd(`EXRAM_OFS_POINTER, 8'h00);
   endtask

   // Burst writes across the top of memory, then reads back with the same wrap.
   task automatic burst_test();
      wr(`EXRAM_OFS_CONTROL, 8'h20);
      rd(`EXRAM_OFS_CONTROL, 8'h20);
      wr(`EXRAM_OFS_POINTER, 8'hfe);
      wr(`EXRAM_OFS_DATA, 8'h11);
      wr(`EXRAM_OFS_DATA, 8'h22);
      wr(`EXRAM_OFS_DATA, 8'h33);
      rd(`EXRAM_OFS_POINTER, 8'h01);
      rd(`EXRAM_OFS_POINTER, 8'h01);
      wr(`EXRAM_OFS_POINTER, 8'hfe);
      rd(`EXRAM_OFS_DATA, 8'h11);
      rd(`EXRAM_OFS_DATA, 8'h22);
      rd(`EXRAM_OFS_DATA, 8'h33);
      rd(`EXRAM_OFS_POINTER, 8'h01);
      wr(`EXRAM_OFS_CONTROL, 8'h00);
      // Burst now off: the wrapped byte reads back and the pointer stays put.
      wr(`EXRAM_OFS_POINTER, 8'h00);
      rd(`EXRAM_OFS_DATA, 8'h33);
      rd(`EXRAM_OFS_POINTER, 8'h00);
   endtask

   // Unmapped places read zero and do not disturb the pointer.
   task automatic unmapped_test();
      wr(5'h05, 8'h77);
      rd(5'h05, 8'h00);
      rd(`EXRAM_OFS_DATA, 8'h00);
      rd(`EXRAM_OFS_POINTER, 8'h01);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset for 16 cycles, let the synchroniser settle, run scenarios.
   initial begin
      repeat (16) @(posedge clk);
      #10;
      arst_n = 1'b1;
      repeat (5) @(posedge clk);
      flags_test();
      single_test();
      burst_test();
      wr(`EXRAM_OFS_POINTER, 8'h01);
      wr(`EXRAM_OFS_DATA, 8'h00);
      unmapped_test();
      test_done();
   end
endmodule
`default_nettype wire

// >>> logic/exram_defines.svh
// Register offsets, field positions, reset values and sizes of the extended RAM port.
`ifndef EXRAM_DEFINES_SVH
`define EXRAM_DEFINES_SVH

`define EXRAM_ADDR_W 5
`define EXRAM_OFS_STATUS 5'h0e
`define EXRAM_OFS_CONTROL 5'h0f
`define EXRAM_OFS_POINTER 5'h10
`define EXRAM_OFS_DATA 5'h13
`define EXRAM_BIT_MAIN_LOW 7
`define EXRAM_BIT_AUX_LOW 6
`define EXRAM_BIT_WBUF_FULL 0
`define EXRAM_BIT_BURST 5
`define EXRAM_RST_POINTER 8'h00
`define EXRAM_RST_BURST 1'b0
`define EXRAM_RST_BYTE 8'h00
`define EXRAM_DEPTH 256
`define EXRAM_WBUF_DEPTH 4

`endif

// >>> logic/exram_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`default_nettype none
module exram_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk, // System clock.
   input wire logic rst_n, // Synchronised reset, active low.
   input wire logic in_valid, // Source offers a word.
   output logic in_ready, // FIFO can take a word.
   input wire logic [WIDTH-1:0] in_data, // Word offered.
   output logic out_valid, // FIFO holds a word.
   input wire logic out_ready, // Sink takes the word.
   output logic [WIDTH-1:0] out_data // Oldest word.
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [WIDTH-1:0] next_store [DEPTH];
   logic [PW-1:0] rd_idx, next_rd_idx, wr_idx, next_wr_idx;
   logic [PW:0] count, next_count;
   logic push, pop;

   // Full and empty come from the count alone, so they never lie about room.
   assign in_ready = (count < (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = store[rd_idx];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Next indices, count and contents.
   always_comb begin
      next_store = store;
      next_rd_idx = rd_idx;
      next_wr_idx = wr_idx;
      next_count = count;
      if (push) begin
         next_store[wr_idx] = in_data;
         next_wr_idx = (wr_idx == PW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
         next_rd_idx = (rd_idx == PW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   // Register the state; contents need no reset since count guards them.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_idx <= '0;
         wr_idx <= '0;
         count <= '0;
      end else begin
         rd_idx <= next_rd_idx;
         wr_idx <= next_wr_idx;
         count <= next_count;
      end
   end

   // Storage is data only.
   always_ff @(posedge clk) begin
      store <= next_store;
   end
endmodule
`default_nettype wire

// >>> logic/exram_pkg.sv
// Types shared by the extended RAM port.
`default_nettype none
package exram_pkg;
   typedef enum logic {EXRAM_IDLE, EXRAM_ACCESS} exram_bus_state_type;
endpackage
`default_nettype wire

// >>> logic/exram_port.sv
// Extended RAM access port with pointer, data window, burst advance and battery flags.
//
// Functional notes
// - Battery low flags read one while below threshold.
// - Memory holds 256 bytes, 8-bit pointer.
// - Pointer register write loads the memory pointer.
// - Data window reads and writes pointed byte.
// - Burst off keeps the pointer unchanged.
// - Pointer advances only with burst enable set.
// - Burst advances at strobe rise, data window only.
// - Pointer wraps from top to zero.
`include "exram_defines.svh"
`default_nettype none
module exram_port
   import exram_pkg::*;
(
   input wire logic clk, // 10 MHz system clock.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic ce_n, // Chip enable pin, active low.
   input wire logic oe_n, // Output enable pin, active low.
   input wire logic we_n, // Write enable pin, active low.
   input wire logic [4:0] addr, // Register address pins.
   input wire logic [7:0] data_in, // Data pins as driven by the host.
   output logic [7:0] data_out, // Data driven onto the pins.
   output logic data_oe, // High while the port drives the data pins.
   input wire logic main_battery_below, // Comparator: main backup battery under threshold.
   input wire logic aux_battery_below // Comparator: auxiliary battery under threshold.
);
   localparam int PIN_W = 18;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers.

   logic [1:0] rst_sync;
   logic rst_n;
   logic [PIN_W-1:0] pins_a, pins_b;
   logic s_ce_n, s_oe_n, s_we_n, main_battery_low_flag, aux_battery_low_flag;
   logic [4:0] s_addr;
   logic [7:0] s_data;

   // Reset is applied asynchronously but is released on the clock.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Every pin passes two flops; only the second stage is used.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_a <= {3'b111, {(PIN_W-3){1'b0}}};
         pins_b <= {3'b111, {(PIN_W-3){1'b0}}};
      end else begin
         pins_a <= {ce_n, oe_n, we_n, addr, data_in, main_battery_below, aux_battery_below};
         pins_b <= pins_a;
      end
   end
   // The synchronised comparator levels are the flags themselves.
   assign {s_ce_n, s_oe_n, s_we_n, s_addr, s_data, main_battery_low_flag,
           aux_battery_low_flag} = pins_b;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus access tracking and register state.

   exram_bus_state_type state, next_state;
   logic [4:0] acc_addr, next_acc_addr;
   logic [7:0] acc_data, next_acc_data;
   logic acc_write, next_acc_write;
   logic [7:0] pointer, next_pointer;
   logic burst_increment_enable, next_burst;
   logic active, end_ev, push, push_ready, drain_valid, drain_ready, advance;
   logic [15:0] drain_word;

   // A write is seen when write enable is low, whatever output enable does.
   assign active = !s_ce_n && (!s_oe_n || !s_we_n);
   // The access ends when chip enable rises or both enables are high; one event per access.
   assign end_ev = (state == EXRAM_ACCESS) && !active;
   assign push = end_ev && acc_write && (acc_addr == `EXRAM_OFS_DATA);
   // A data write that finds the buffer full is dropped and does not advance.
   assign advance = end_ev && burst_increment_enable && (acc_addr == `EXRAM_OFS_DATA) &&
                    (!acc_write || push_ready);

   // Next access record, pointer and burst bit.
   always_comb begin
      next_state = active ? EXRAM_ACCESS : EXRAM_IDLE;
      next_acc_addr = acc_addr;
      next_acc_data = acc_data;
      next_acc_write = acc_write;
      next_pointer = pointer;
      next_burst = burst_increment_enable;
      if (active) begin
         // Address and data are taken up to the last cycle before the strobe rises.
         next_acc_addr = s_addr;
         next_acc_data = s_data;
         next_acc_write = !s_we_n;
      end
      if (end_ev && acc_write && (acc_addr == `EXRAM_OFS_POINTER)) begin
         next_pointer = acc_data;
      end else if (advance) begin
         next_pointer = pointer + 8'h01;
      end
      if (end_ev && acc_write && (acc_addr == `EXRAM_OFS_CONTROL)) begin
         next_burst = acc_data[`EXRAM_BIT_BURST];
      end
   end

   // Register the access record, pointer and burst bit.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= EXRAM_IDLE;
         acc_addr <= 5'h00;
         acc_data <= `EXRAM_RST_BYTE;
         acc_write <= 1'b0;
         pointer <= `EXRAM_RST_POINTER;
         burst_increment_enable <= `EXRAM_RST_BURST;
      end else begin
         state <= next_state;
         acc_addr <= next_acc_addr;
         acc_data <= next_acc_data;
         acc_write <= next_acc_write;
         pointer <= next_pointer;
         burst_increment_enable <= next_burst;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write buffer and memory array.

   logic [7:0] mem [`EXRAM_DEPTH];
   logic [7:0] next_mem [`EXRAM_DEPTH];
   logic reading;

   assign reading = active && s_we_n;
   // The single memory port serves reads first; writes wait in the buffer.
   assign drain_ready = !reading;

   exram_fifo #(
      .WIDTH(16),
      .DEPTH(`EXRAM_WBUF_DEPTH)
   ) u_wbuf (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_ready(push_ready),
      .in_data({pointer, acc_data}),
      .out_valid(drain_valid),
      .out_ready(drain_ready),
      .out_data(drain_word)
   );

   // One write port per entry; battery-backed contents are not reset.
   genvar gi;
   generate
      for (gi = 0; gi < `EXRAM_DEPTH; gi++) begin : g_mem
         always_comb begin
            next_mem[gi] = mem[gi];
            if (drain_valid && drain_ready && (drain_word[15:8] == 8'(gi))) begin
               next_mem[gi] = drain_word[7:0];
            end
         end
         always_ff @(posedge clk) begin
            mem[gi] <= next_mem[gi];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Read data path.

   logic [7:0] next_data_out;
   logic next_data_oe;

   // Address decode for reads; unmapped addresses read zero.
   always_comb begin
      next_data_oe = reading && !s_oe_n;
      next_data_out = 8'h00;
      if (s_addr == `EXRAM_OFS_POINTER) begin
         next_data_out = pointer;
      end else if (s_addr == `EXRAM_OFS_DATA) begin
         next_data_out = mem[pointer];
      end else if (s_addr == `EXRAM_OFS_CONTROL) begin
         next_data_out[`EXRAM_BIT_BURST] = burst_increment_enable;
      end else if (s_addr == `EXRAM_OFS_STATUS) begin
         next_data_out[`EXRAM_BIT_MAIN_LOW] = main_battery_low_flag;
         next_data_out[`EXRAM_BIT_AUX_LOW] = aux_battery_low_flag;
         next_data_out[`EXRAM_BIT_WBUF_FULL] = !push_ready;
      end
   end

   // Pin outputs come straight from flops.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
      end else begin
         data_out <= next_data_out;
         data_oe <= next_data_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   logic [7:0] mem_at_ptr;
   assign mem_at_ptr = mem[pointer];

   sequence data_access_end_s;
      end_ev && (acc_addr == `EXRAM_OFS_DATA);
   endsequence
   sequence burst_read_end_s;
      data_access_end_s and (burst_increment_enable && !acc_write);
   endsequence

   pointer_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      end_ev && acc_write && (acc_addr == `EXRAM_OFS_POINTER) |=> pointer == $past(acc_data))
      else $error("pointer not loaded by pointer write");
   pointer_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      data_access_end_s and !burst_increment_enable |=> $stable(pointer))
      else $error("pointer moved with burst off");
   burst_advance_a: assert property (@(posedge clk) disable iff (!rst_n)
      burst_read_end_s |=> pointer == 8'($past(pointer) + 8'h01))
      else $error("burst read did not advance pointer");
   pointer_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
      burst_read_end_s and (pointer == 8'hff) |=> pointer == 8'h00)
      else $error("pointer did not wrap to zero");
   burst_only_a: assert property (@(posedge clk) disable iff (!rst_n)
      pointer == 8'($past(pointer) + 8'h01) && !$stable(pointer) |->
      $past(burst_increment_enable) || $past(acc_addr) == `EXRAM_OFS_POINTER)
      else $error("pointer advanced without burst enable");
   single_advance_a: assert property (@(posedge clk) disable iff (!rst_n)
      advance |=> !advance ##1 !advance)
      else $error("pointer advanced twice in one access");
   window_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      reading && !s_oe_n && s_addr == `EXRAM_OFS_DATA |=> data_oe && data_out == $past(mem_at_ptr))
      else $error("data window read returned wrong byte");
   window_store_a: assert property (@(posedge clk) disable iff (!rst_n)
      drain_valid && drain_ready |=> mem[$past(drain_word[15:8])] == $past(drain_word[7:0]))
      else $error("buffered write not stored");
   battery_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      reading && !s_oe_n && s_addr == `EXRAM_OFS_STATUS |=>
      data_out[`EXRAM_BIT_MAIN_LOW] == $past(main_battery_low_flag) &&
      data_out[`EXRAM_BIT_AUX_LOW] == $past(aux_battery_low_flag))
      else $error("battery flag read wrong");
endmodule
`default_nettype wire
